/* rtl/cp_clock_power_mode_control.sv */
// Call processor clock source switching and power mode controller
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
module cp_clock_power_mode_control #(
    parameter int unsigned NUM_PERIPH = 16,
    parameter int unsigned NUM_ASYNC = 4,
    parameter int unsigned NUM_IRQ = 32
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [31:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    input wire logic i_mem_busy,
    input wire logic [NUM_IRQ-1:0] i_irq_lines,
    input wire logic [NUM_ASYNC-1:0] i_async_wake,
    output cp_clk_pkg::clk_out_t o_clk,
    output logic [NUM_PERIPH-1:0] o_periph_clk_en,
    output logic o_mem_hold,
    output logic o_irq
);
    import cp_clk_pkg::*;

    logic aw_ready_q;
    logic w_ready_q;
    logic b_valid_q;
    logic [1:0] b_resp_q;
    logic ar_ready_q;
    logic r_valid_q;
    logic [31:0] r_data_q;
    logic [1:0] r_resp_q;
    logic [ADDR_W-1:0] wr_addr_q;
    logic [31:0] wr_data_q;
    logic [3:0] wr_strb_q;
    logic wr_fire;
    logic wr_hit;
    logic [31:0] wr_mask;
    logic [31:0] wr_ones;

    logic pll_sel_q;
    logic slow_sel_q;
    logic gate_all_q;
    logic rtc_xtal_q;
    logic [NUM_PERIPH-1:0] periph_en_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    logic [IRQ_W-1:0] irq_stat_d;

    mode_t mode_q;
    sw_t sw_q;
    src_t src_q;
    src_t target;
    src_t sw_target_q;
    logic [GAP_W-1:0] gap_q;
    logic [2:0] src_en_q;
    logic pause_req;
    logic wake_any;
    logic wake_async;
    logic waking;
    logic gated;
    logic stay_gated;
    logic steady_mode;
    logic [NUM_ASYNC-1:0] async_s1_q;
    logic [NUM_ASYNC-1:0] async_s2_q;
    logic [NUM_ASYNC-1:0] async_s3_q;

    // Bus write side: address and data are taken in either order
    assign wr_fire = !aw_ready_q && !w_ready_q && !b_valid_q;
    assign wr_mask = {{8{wr_strb_q[3]}}, {8{wr_strb_q[2]}},
                      {8{wr_strb_q[1]}}, {8{wr_strb_q[0]}}};
    assign wr_ones = wr_data_q & wr_mask;

    always_comb
    begin
        case (wr_addr_q)
            PAUSE_OFFS, CLK_MGMT_OFFS, CLK_STAT_OFFS, CLK_CTRL_OFFS,
            PERIPH_EN_OFFS, IRQ_STAT_OFFS, IRQ_MASK_OFFS: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            aw_ready_q <= 1'b1;
            w_ready_q <= 1'b1;
            b_valid_q <= 1'b0;
            b_resp_q <= RESP_OKAY;
            wr_addr_q <= '0;
            wr_data_q <= '0;
            wr_strb_q <= '0;
        end
        else
        begin
            if (i_awvalid && aw_ready_q)
            begin
                aw_ready_q <= 1'b0;
                wr_addr_q <= i_awaddr[ADDR_W-1:0];
            end
            if (i_wvalid && w_ready_q)
            begin
                w_ready_q <= 1'b0;
                wr_data_q <= i_wdata;
                wr_strb_q <= i_wstrb;
            end
            if (wr_fire)
            begin
                b_valid_q <= 1'b1;
                b_resp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (b_valid_q && i_bready)
            begin
                b_valid_q <= 1'b0;
                aw_ready_q <= 1'b1;
                w_ready_q <= 1'b1;
            end
        end
    end

    // Bus read side: data is sampled on the address handshake
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            ar_ready_q <= 1'b1;
            r_valid_q <= 1'b0;
            r_data_q <= '0;
            r_resp_q <= RESP_OKAY;
        end
        else if (i_arvalid && ar_ready_q)
        begin
            ar_ready_q <= 1'b0;
            r_valid_q <= 1'b1;
            r_resp_q <= RESP_OKAY;
            r_data_q <= '0;
            case (i_araddr[ADDR_W-1:0])
                PAUSE_OFFS:
                    r_data_q[PAUSE_BIT] <= (mode_q != MODE_FULL)
                        && (mode_q != MODE_LOW);
                CLK_MGMT_OFFS:
                begin
                    r_data_q[MGMT_PLL_BIT] <= pll_sel_q;
                    r_data_q[MGMT_SLOW_BIT] <= slow_sel_q;
                end
                CLK_STAT_OFFS:
                begin
                    r_data_q[STAT_MODE_LSB +: 3] <= mode_q;
                    r_data_q[STAT_SRC_LSB +: 2] <= src_q;
                    r_data_q[STAT_SWITCHING_BIT] <= (sw_q != SW_STEADY);
                    r_data_q[STAT_HOLD_BIT] <= o_mem_hold;
                end
                CLK_CTRL_OFFS:
                begin
                    r_data_q[CTRL_GATE_BIT] <= gate_all_q;
                    r_data_q[CTRL_RTC_XTAL_BIT] <= rtc_xtal_q;
                end
                PERIPH_EN_OFFS: r_data_q[NUM_PERIPH-1:0] <= periph_en_q;
                IRQ_STAT_OFFS: r_data_q[IRQ_W-1:0] <= irq_stat_q;
                IRQ_MASK_OFFS: r_data_q[IRQ_W-1:0] <= irq_mask_q;
                default: r_resp_q <= RESP_SLVERR;
            endcase
        end
        else if (r_valid_q && i_rready)
        begin
            r_valid_q <= 1'b0;
            ar_ready_q <= 1'b1;
        end
    end

    // Control registers written by software
    assign pause_req = wr_fire && (wr_addr_q == PAUSE_OFFS)
        && wr_ones[PAUSE_BIT]; // RQ11

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            pll_sel_q <= 1'b0; // RQ18
            slow_sel_q <= 1'b0; // RQ18
        end
        else if (waking)
        begin
            // Wake forces full speed; from a low-speed mode it lands on the
            // reference clock since the PLL may have been left unlocked
            slow_sel_q <= 1'b0; // RQ14
            if (mode_q == MODE_LOW_IDLE || mode_q == MODE_LOW_GATED)
                pll_sel_q <= 1'b0; // RQ16
        end
        else if (wr_fire && wr_addr_q == CLK_MGMT_OFFS)
        begin
            if (wr_strb_q[0])
            begin
                pll_sel_q <= wr_data_q[MGMT_PLL_BIT]; // RQ10
                slow_sel_q <= wr_data_q[MGMT_SLOW_BIT]; // RQ15
            end
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            gate_all_q <= 1'b0;
            rtc_xtal_q <= 1'b0;
        end
        else if (wr_fire && wr_addr_q == CLK_CTRL_OFFS && wr_strb_q[0])
        begin
            gate_all_q <= wr_data_q[CTRL_GATE_BIT];
            rtc_xtal_q <= wr_data_q[CTRL_RTC_XTAL_BIT];
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
            periph_en_q <= {NUM_PERIPH{PERIPH_EN_RESET_BIT}};
        else if (wr_fire && wr_addr_q == PERIPH_EN_OFFS)
            periph_en_q <= (periph_en_q & ~wr_mask[NUM_PERIPH-1:0])
                | wr_ones[NUM_PERIPH-1:0]; // RQ17
    end

    // Asynchronous wake pins; a level counts once stages two and three agree
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            async_s1_q <= '0;
            async_s2_q <= '0;
            async_s3_q <= '0;
        end
        else
        begin
            async_s1_q <= i_async_wake;
            async_s2_q <= async_s1_q;
            async_s3_q <= async_s2_q;
        end
    end

    assign wake_async = |(async_s2_q & async_s3_q); // RQ9
    assign wake_any = (|i_irq_lines) || wake_async; // RQ4
    assign gated = (mode_q == MODE_FULL_GATED) || (mode_q == MODE_LOW_GATED);
    // Clocks come back on the same edge that drops the memory hold
    assign stay_gated = gated && !waking;
    assign steady_mode = (mode_q == MODE_FULL) || (mode_q == MODE_LOW);
    assign waking = ((mode_q == MODE_FULL_IDLE || mode_q == MODE_LOW_IDLE)
        && wake_any) || (gated && wake_async); // RQ9

    // Power mode sequencing; full or low follows the requested source, so
    // a wake reads as full speed while the switch back is still running
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
            mode_q <= MODE_FULL; // RQ18
        else
        begin
            case (mode_q) // RQ1
                MODE_FULL, MODE_LOW:
                    if (pause_req)
                        mode_q <= MODE_DRAIN; // RQ11
                    else
                        mode_q <= (target == SRC_XTAL) ? MODE_LOW
                            : MODE_FULL; // RQ6
                MODE_DRAIN:
                    // Wait for the bus to go quiet and any switch to finish
                    if (!i_mem_busy && sw_q == SW_STEADY) // RQ12
                    begin
                        if (gate_all_q) // RQ13
                            mode_q <= (src_q == SRC_XTAL) ? MODE_LOW_GATED
                                : MODE_FULL_GATED; // RQ7
                        else
                            mode_q <= (src_q == SRC_XTAL) ? MODE_LOW_IDLE
                                : MODE_FULL_IDLE; // RQ3
                    end
                MODE_FULL_IDLE, MODE_LOW_IDLE, MODE_FULL_GATED,
                MODE_LOW_GATED:
                    if (waking)
                        mode_q <= MODE_FULL; // RQ14
                default: mode_q <= MODE_FULL;
            endcase
        end
    end

    // Break-before-make source switching: every source gate is closed for a
    // full gap before the select moves, so no runt pulse can reach a clock
    always_comb
    begin
        if (slow_sel_q)
            target = SRC_XTAL; // RQ5
        else if (pll_sel_q)
            target = SRC_PLL; // RQ2
        else
            target = SRC_REF; // RQ2
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            sw_q <= SW_STEADY;
            src_q <= SRC_REF; // RQ18
            sw_target_q <= SRC_REF;
            src_en_q <= 3'h1;
            gap_q <= '0;
        end
        else
        begin
            case (sw_q)
                SW_STEADY:
                begin
                    if (steady_mode && target != src_q) // RQ10
                    begin
                        sw_target_q <= target;
                        src_en_q <= 3'h0; // RQ19
                        gap_q <= GAP_W'(SWITCH_GAP_CYCLES - 1);
                        sw_q <= SW_BREAK;
                    end
                end
                SW_BREAK:
                begin
                    if (gap_q == '0)
                    begin
                        src_q <= sw_target_q; // RQ19
                        gap_q <= GAP_W'(SWITCH_GAP_CYCLES - 1);
                        sw_q <= SW_MAKE;
                    end
                    else
                        gap_q <= gap_q - 1'b1;
                end
                SW_MAKE:
                begin
                    if (gap_q == '0)
                    begin
                        src_en_q <= 3'h1 << src_q; // RQ19
                        sw_q <= SW_STEADY;
                    end
                    else
                        gap_q <= gap_q - 1'b1;
                end
                default: sw_q <= SW_STEADY;
            endcase
        end
    end

    // Clock gate and hold outputs
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            o_clk <= '{src_sel: SRC_REF, src_en: 3'h1, core_en: 1'b1,
                       switch_en: 1'b1, rtc_en: 1'b1};
            o_periph_clk_en <= '0;
            o_mem_hold <= 1'b0;
        end
        else
        begin
            o_clk.src_sel <= src_q;
            // The selected source stays open in gated modes to clock the
            // switching logic itself
            o_clk.src_en <= src_en_q; // RQ7
            o_clk.core_en <= !stay_gated; // RQ7
            o_clk.switch_en <= 1'b1;
            o_clk.rtc_en <= !stay_gated || rtc_xtal_q; // RQ8
            o_periph_clk_en <= stay_gated ? '0 : periph_en_q; // RQ4 RQ17
            o_mem_hold <= !steady_mode && !waking; // RQ3
        end
    end

    // Interrupt status: a hardware set wins over a software clear
    always_comb
    begin
        irq_set = '0;
        irq_set[IRQ_IDLE_BIT] = (mode_q == MODE_DRAIN) && !i_mem_busy
            && (sw_q == SW_STEADY);
        irq_set[IRQ_WAKE_BIT] = waking;
        irq_set[IRQ_SWITCH_BIT] = (sw_q == SW_MAKE) && (gap_q == '0);
        irq_clr = '0;
        if (wr_fire && wr_addr_q == IRQ_STAT_OFFS)
            irq_clr = wr_ones[IRQ_W-1:0];
        irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            irq_stat_q <= '0;
            irq_mask_q <= IRQ_MASK_RESET;
            o_irq <= 1'b0;
        end
        else
        begin
            irq_stat_q <= irq_stat_d;
            if (wr_fire && wr_addr_q == IRQ_MASK_OFFS)
                irq_mask_q <= (irq_mask_q & ~wr_mask[IRQ_W-1:0])
                    | wr_ones[IRQ_W-1:0];
            o_irq <= |(irq_stat_d & irq_mask_q);
        end
    end

    assign o_awready = aw_ready_q;
    assign o_wready = w_ready_q;
    assign o_bvalid = b_valid_q;
    assign o_bresp = b_resp_q;
    assign o_arready = ar_ready_q;
    assign o_rvalid = r_valid_q;
    assign o_rdata = r_data_q;
    assign o_rresp = r_resp_q;
endmodule // cp_clock_power_mode_control

/* rtl/cp_clk_pkg.sv */
// Constants, types and register map of the call processor clock/power control
// Summary of operation
// RQ1 - Six modes: full, low, their idle and their gated forms.
// RQ2 - Full speed runs core and peripherals on reference or PLL clock.
// RQ3 - Idle modes hold core and DMA memory requests until an interrupt.
// RQ4 - Idle keeps peripherals clocked; any peripheral interrupt wakes.
// RQ5 - Low speed runs core and enabled peripherals on the crystal.
// RQ6 - Low speed left only by software switch or low idle/gated entry.
// RQ7 - Gated modes stop core and peripheral clocks; switch logic runs.
// RQ8 - Gated modes keep the real-time clock running on the crystal; here only while control bit 1 is set.
// RQ9 - Gated modes exit only on an asynchronous wake pin.
// RQ10 - A source select write makes the switch logic change source.
// RQ11 - Writing 1 to pause bit 0 starts idle entry.
// RQ12 - Idle entered only once outstanding memory operations complete.
// RQ13 - Software sets gate-all before pausing to reach a gated mode.
// RQ14 - Waking from idle or gated returns to full speed by itself.
// RQ15 - Writing 1 to management bit 2 selects the crystal clock.
// RQ16 - Waking from low idle resumes on the reference clock.
// RQ17 - Software can stop each peripheral's clock.
// RQ18 - After reset the core runs from the reference clock.
// RQ19 - Every source change is glitch-free, no shortened pulse.
package cp_clk_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam logic [ADDR_W-1:0] PAUSE_OFFS = 8'h00;
    localparam logic [ADDR_W-1:0] CLK_MGMT_OFFS = 8'h04;
    localparam logic [ADDR_W-1:0] CLK_STAT_OFFS = 8'h14;
    localparam logic [ADDR_W-1:0] CLK_CTRL_OFFS = 8'h18;
    localparam logic [ADDR_W-1:0] PERIPH_EN_OFFS = 8'h2c;
    localparam logic [ADDR_W-1:0] IRQ_STAT_OFFS = 8'h58;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFFS = 8'h5c;

    localparam int unsigned PAUSE_BIT = 0;
    localparam int unsigned MGMT_PLL_BIT = 0;
    localparam int unsigned MGMT_SLOW_BIT = 2;
    localparam int unsigned CTRL_GATE_BIT = 0;
    localparam int unsigned CTRL_RTC_XTAL_BIT = 1;
    localparam int unsigned STAT_MODE_LSB = 0;
    localparam int unsigned STAT_SRC_LSB = 4;
    localparam int unsigned STAT_SWITCHING_BIT = 6;
    localparam int unsigned STAT_HOLD_BIT = 7;

    localparam int unsigned IRQ_W = 3;
    localparam int unsigned IRQ_IDLE_BIT = 0;
    localparam int unsigned IRQ_WAKE_BIT = 1;
    localparam int unsigned IRQ_SWITCH_BIT = 2;

    localparam logic PERIPH_EN_RESET_BIT = 1'b1;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Break-before-make gap around every source change
    localparam int unsigned CLOCK_MHZ = 250;
    localparam int unsigned SWITCH_GAP_NS = 40;
    localparam int unsigned SWITCH_GAP_CYCLES =
        (SWITCH_GAP_NS * CLOCK_MHZ + 999) / 1000;
    localparam int unsigned GAP_W = 8;

    typedef enum logic [1:0] {SRC_REF, SRC_PLL, SRC_XTAL} src_t;
    typedef enum logic [2:0] {
        MODE_FULL, MODE_LOW, MODE_DRAIN, MODE_FULL_IDLE, MODE_LOW_IDLE,
        MODE_FULL_GATED, MODE_LOW_GATED
    } mode_t;
    typedef enum logic [1:0] {SW_STEADY, SW_BREAK, SW_MAKE} sw_t;

    typedef struct packed {
        src_t src_sel;
        logic [2:0] src_en;
        logic core_en;
        logic switch_en;
        logic rtc_en;
    } clk_out_t;
endpackage

/* testbench/cp_clk_chk.sv */
// Concurrent assertions on the clock and power mode controller ports
`timescale 1ns/1ps
module cp_clk_chk
    import cp_clk_pkg::*;
#(
    parameter int unsigned NUM_PERIPH = 16,
    parameter int unsigned NUM_ASYNC = 4,
    parameter int unsigned NUM_IRQ = 32
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_mem_busy,
    input wire logic [NUM_IRQ-1:0] i_irq_lines,
    input wire logic [NUM_ASYNC-1:0] i_async_wake,
    input wire cp_clk_pkg::clk_out_t o_clk,
    input wire logic [NUM_PERIPH-1:0] o_periph_clk_en,
    input wire logic o_mem_hold
);
    logic [7:0] quiet_q;
    logic [7:0] gap_q;

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    // Cycles since the last cause that may legally wake the core
    always_ff @(posedge i_clock)
    begin
        if (i_rst || (|i_async_wake) || ((|i_irq_lines) && (|o_periph_clk_en)))
            quiet_q <= 8'h00;
        else if (quiet_q != 8'hff)
            quiet_q <= quiet_q + 8'h01;
    end

    // Length of the current run with every source gate shut
    always_ff @(posedge i_clock)
    begin
        if (i_rst || o_clk.src_en != 3'h0)
            gap_q <= 8'h00;
        else if (gap_q != 8'hff)
            gap_q <= gap_q + 8'h01;
    end

    AST_SRC_ONEHOT: assert property (
        o_clk.src_en != 3'h0 |-> o_clk.src_en == (3'h1 << o_clk.src_sel))
        else $error("source gate differs from selected source");
    AST_GAP_MIN: assert property (
        $rose(|o_clk.src_en) |-> gap_q >= 8'h0a)
        else $error("source gate reopened without a full gap");
    AST_GAP_MAX: assert property (
        gap_q <= 8'h1e)
        else $error("source change did not finish");
    AST_SWITCH_CLOCKED: assert property (
        !o_clk.core_en |-> o_clk.switch_en
            && o_clk.src_en == (3'h1 << o_clk.src_sel))
        else $error("switching logic lost its clock");
    AST_RTC_AWAKE: assert property (
        !o_mem_hold |-> o_clk.rtc_en)
        else $error("rtc clock off outside a gated mode");
    AST_IDLE_WAKE: assert property (
        o_mem_hold && (|o_periph_clk_en) && (|i_irq_lines) && !i_mem_busy
        |-> ##[1:30] !o_mem_hold)
        else $error("interrupt did not end idle");
    AST_HOLD_STAYS: assert property (
        o_mem_hold && quiet_q >= 8'h08
        && !((|i_irq_lines) && (|o_periph_clk_en)) |=> o_mem_hold)
        else $error("memory hold dropped without a wake cause");
    AST_WAKE_FAST: assert property (
        $fell(o_mem_hold) |-> ##[0:40] o_clk.src_sel != SRC_XTAL)
        else $error("wake did not return to a fast source");
endmodule // cp_clk_chk

bind cp_clock_power_mode_control cp_clk_chk #(.NUM_PERIPH(NUM_PERIPH),
    .NUM_ASYNC(NUM_ASYNC), .NUM_IRQ(NUM_IRQ)) cp_clk_chk_i (
    .i_clock(i_clock), .i_rst(i_rst), .i_mem_busy(i_mem_busy),
    .i_irq_lines(i_irq_lines), .i_async_wake(i_async_wake), .o_clk(o_clk),
    .o_periph_clk_en(o_periph_clk_en), .o_mem_hold(o_mem_hold));

/* testbench/core_irq_model.sv */
// Core, DMA and interrupt source model on the controller's far side
`timescale 1ns/1ps
module core_irq_model (
    input wire logic i_clock,
    input wire logic i_mem_hold,
    input wire logic [7:0] i_ops,
    input wire logic [31:0] i_irq_req,
    input wire logic [3:0] i_async_req,
    output logic o_mem_busy,
    output logic [31:0] o_irq_lines,
    output logic [3:0] o_async_wake
);
    logic [7:0] ops_q = 8'h00;
    logic [31:0] irq_q = 32'h0;
    logic [3:0] pin_q = 4'h0;
    // New transfers start only while requests are not held off
    always @(posedge i_clock)
    begin
        if (i_ops != 8'h00 && !i_mem_hold)
            ops_q <= i_ops;
        else if (ops_q != 8'h00)
            ops_q <= ops_q - 8'h01;
        irq_q <= i_irq_req;
        pin_q <= i_async_req;
    end
    assign o_mem_busy = ops_q != 8'h00;
    assign o_irq_lines = irq_q;
    assign o_async_wake = pin_q;
endmodule // core_irq_model

/* testbench/testbench.sv */
// Register level testbench of the clock and power mode controller
`timescale 1ns/1ps
module testbench;
    import cp_clk_pkg::*;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
    logic [7:0] ops = 8'h00;
    logic [31:0] irq_req = 32'h0;
    logic [3:0] async_req = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, busy, hold, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, irq_lines;
    logic [3:0] async_wake;
    logic [15:0] periph_en;
    clk_out_t clk_out;
    int failures = 0;
    int checks_done = 0;
    int cyc = 0;

    always #2 i_clock = ~i_clock;

    cp_clock_power_mode_control cp_clock_power_mode_control_i (
        .i_clock(i_clock), .i_rst(i_rst), .i_awvalid(awvalid),
        .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid),
        .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'hf),
        .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
        .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
        .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata),
        .o_rresp(rresp), .i_mem_busy(busy), .i_irq_lines(irq_lines),
        .i_async_wake(async_wake), .o_clk(clk_out),
        .o_periph_clk_en(periph_en), .o_mem_hold(hold), .o_irq(irq));

    core_irq_model core_irq_model_i (
        .i_clock(i_clock), .i_mem_hold(hold), .i_ops(ops),
        .i_irq_req(irq_req), .i_async_req(async_req), .o_mem_busy(busy),
        .o_irq_lines(irq_lines), .o_async_wake(async_wake));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        if (failures == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        logic ha, hw, hb;
        hb = 1'b0;
        @(posedge i_clock);
        awaddr <= {24'h0, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!hb)
        begin
            @(negedge i_clock);
            ha = awvalid && awready;
            hw = wvalid && wready;
            hb = bvalid;
            if (hb)
                chk({30'h0, bresp}, {30'h0, r});
            @(posedge i_clock);
            if (ha)
                awvalid <= 1'b0;
            if (hw)
                wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e, input logic [1:0] r);
        logic ha, hr;
        hr = 1'b0;
        @(posedge i_clock);
        araddr <= {24'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!hr)
        begin
            @(negedge i_clock);
            ha = arvalid && arready;
            hr = rvalid;
            if (hr)
            begin
                chk(rdata & m, e);
                chk({30'h0, rresp}, {30'h0, r});
            end
            @(posedge i_clock);
            if (ha)
                arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask

    // Bounded waits; the check inside reports a wait that ran out
    task automatic wait_src(input logic [2:0] en);
        int n;
        n = 0;
        while (clk_out.src_en !== en && n < 200)
        begin
            @(negedge i_clock);
            n++;
        end
        chk({29'h0, clk_out.src_en}, {29'h0, en});
    endtask

    task automatic wait_hold(input logic v);
        int n;
        n = 0;
        while (hold !== v && n < 200)
        begin
            @(negedge i_clock);
            n++;
        end
        chk({31'h0, hold}, {31'h0, v});
    endtask

    task automatic sleep(input logic [31:0] ctrl, input logic [31:0] mode);
        wr(CLK_CTRL_OFFS, ctrl, RESP_OKAY);
        wr(PAUSE_OFFS, 32'h1, RESP_OKAY);
        wait_hold(1'b1);
        repeat (3) @(negedge i_clock);
        rd(CLK_STAT_OFFS, 32'h7, mode, RESP_OKAY);
    endtask

    // Async pins stay up well past the three-stage synchroniser
    task automatic wake(input logic [31:0] lines, input logic [3:0] pins);
        @(posedge i_clock);
        irq_req <= lines;
        async_req <= pins;
        repeat (6) @(posedge i_clock);
        irq_req <= 32'h0;
        async_req <= 4'h0;
    endtask

    always @(posedge i_clock)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            end_sim();
        end
    end

    initial
    begin
        repeat (6) @(posedge i_clock);
        i_rst <= 1'b0;
        @(negedge i_clock);
        chk({29'h0, clk_out.src_en}, 32'h1);
        rd(CLK_STAT_OFFS, 32'h37, 32'h0, RESP_OKAY);
        rd(PERIPH_EN_OFFS, 32'hffff, 32'hffff, RESP_OKAY);
        rd(IRQ_MASK_OFFS, 32'h7, 32'h0, RESP_OKAY);
        rd(8'h08, 32'hffffffff, 32'h0, RESP_SLVERR);
        wr(8'h08, 32'h1, RESP_SLVERR);
        wr(PERIPH_EN_OFFS, 32'hf0, RESP_OKAY);
        @(negedge i_clock);
        chk({16'h0, periph_en}, 32'hf0);
        wr(PERIPH_EN_OFFS, 32'hffff, RESP_OKAY);
        wr(IRQ_MASK_OFFS, 32'h4, RESP_OKAY);
        wr(CLK_MGMT_OFFS, 32'h4, RESP_OKAY);
        wait_src(3'h4);
        chk({30'h0, clk_out.src_sel}, {30'h0, SRC_XTAL});
        repeat (2) @(negedge i_clock);
        chk({31'h0, irq}, 32'h1);
        wr(IRQ_MASK_OFFS, 32'h0, RESP_OKAY);
        @(negedge i_clock);
        chk({31'h0, irq}, 32'h0);
        wr(IRQ_MASK_OFFS, 32'h4, RESP_OKAY);
        @(negedge i_clock);
        chk({31'h0, irq}, 32'h1);
        wr(IRQ_STAT_OFFS, 32'h4, RESP_OKAY);
        @(negedge i_clock);
        chk({31'h0, irq}, 32'h0);
        rd(CLK_STAT_OFFS, 32'h7, 32'h1, RESP_OKAY);
        // Outstanding transfers must delay idle entry
        @(posedge i_clock);
        ops <= 8'h28;
        @(posedge i_clock);
        ops <= 8'h00;
        sleep(32'h0, 32'h2);
        repeat (60) @(negedge i_clock);
        rd(CLK_STAT_OFFS, 32'h7, 32'h4, RESP_OKAY);
        rd(PAUSE_OFFS, 32'h1, 32'h1, RESP_OKAY);
        chk({16'h0, periph_en}, 32'hffff);
        wake(32'h20, 4'h0);
        wait_hold(1'b0);
        rd(CLK_STAT_OFFS, 32'h7, 32'h0, RESP_OKAY);
        wait_src(3'h1);
        chk({30'h0, clk_out.src_sel}, {30'h0, SRC_REF});
        rd(IRQ_STAT_OFFS, 32'h3, 32'h3, RESP_OKAY);
        wr(IRQ_STAT_OFFS, 32'h7, RESP_OKAY);
        sleep(32'h1, 32'h5);
        chk({16'h0, periph_en}, 32'h0);
        chk({31'h0, clk_out.core_en}, 32'h0);
        chk({31'h0, clk_out.rtc_en}, 32'h0);
        wake(32'h20, 4'h0);
        repeat (10) @(negedge i_clock);
        chk({31'h0, hold}, 32'h1);
        wake(32'h0, 4'h1);
        wait_hold(1'b0);
        rd(CLK_STAT_OFFS, 32'h7, 32'h0, RESP_OKAY);
        wr(CLK_MGMT_OFFS, 32'h1, RESP_OKAY);
        wait_src(3'h2);
        sleep(32'h0, 32'h3);
        wake(32'h1, 4'h0);
        wait_hold(1'b0);
        chk({30'h0, clk_out.src_sel}, {30'h0, SRC_PLL});
        wr(CLK_MGMT_OFFS, 32'h5, RESP_OKAY);
        wait_src(3'h4);
        sleep(32'h3, 32'h6);
        chk({31'h0, clk_out.rtc_en}, 32'h1);
        wake(32'h0, 4'h8);
        wait_hold(1'b0);
        wait_src(3'h1);
        chk({30'h0, clk_out.src_sel}, {30'h0, SRC_REF});
        end_sim();
    end
endmodule // testbench
